/* tics_asserts.sv */
// Purpose: port-level checks for tics_top
// Assumes: bound to every tics_top instance
// Notes: reset values checked two edges after release
`timescale 1ns/1ps
module tics_asserts #(parameter int NCH = 4, parameter int NLANE = 3) (
    // system side
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_down_pin,
    input wire logic route_valid,
    input wire logic tx_enable,
    input wire logic rx_connect,
    input wire logic [4*NCH-1:0] eq_gain,
    input wire logic [1:0] pll_bw,
    input wire logic recal_pulse,
    // link side
    input wire logic clk_link,
    input wire logic dru_locked,
    input wire logic [NLANE-1:0] tx_bits,
    input wire logic [NLANE-1:0] preemph_en,
    input wire logic [2*NLANE-1:0] lane_skew
);
    logic [1:0] cyc_ff;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) cyc_ff <= 2'h0;
        else if (cyc_ff != 2'h3) cyc_ff <= cyc_ff + 2'h1;
    end
    property p_pd; @(posedge clk_sys) disable iff (!nrst)
        power_down_pin[*6] |-> !tx_enable && !rx_connect; endproperty
    a_pd: assert property (p_pd) else $error("outputs on in power down");
    property p_vld; @(posedge clk_sys) disable iff (!nrst)
        route_valid |-> tx_enable && rx_connect; endproperty
    a_vld: assert property (p_vld) else $error("route valid while off");
    property p_rcl; @(posedge clk_sys) disable iff (!nrst)
        recal_pulse |=> !recal_pulse; endproperty
    a_rcl: assert property (p_rcl) else $error("recal pulse too long");
    property p_rst; @(posedge clk_sys) disable iff (!nrst)
        cyc_ff == 2'h1 |-> eq_gain == {NCH{4'hc}} && pll_bw == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("bad settings after reset");
    property p_sda; @(posedge clk_sys) disable iff (!nrst)
        sda_oe |-> !sda_out; endproperty
    a_sda: assert property (p_sda) else $error("sda driven high");
    property p_skw; @(posedge clk_link) disable iff (!nrst)
        lane_skew[1:0] != 2'h3 && lane_skew[3:2] != 2'h3 && lane_skew[5:4] != 2'h3; endproperty
    a_skw: assert property (p_skw) else $error("lane skew above two");
    property p_frz; @(posedge clk_link) disable iff (!nrst)
        dru_locked[*5] |-> $stable(lane_skew); endproperty
    a_frz: assert property (p_frz) else $error("skew moved while locked");
    property p_pre; @(posedge clk_link) disable iff (!nrst)
        (preemph_en & ~($past(tx_bits) ^ $past(tx_bits, 2))) == '0; endproperty
    a_pre: assert property (p_pre) else $error("emphasis without transition");
    c_rcl: cover property (@(posedge clk_sys) recal_pulse);
    c_off: cover property (@(posedge clk_sys) $fell(route_valid));
    c_pre: cover property (@(posedge clk_link) preemph_en != '0);
endmodule
bind tics_top tics_asserts #(.NCH(NCH), .NLANE(NLANE)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .sda_out(sda_out), .sda_oe(sda_oe), .power_down_pin(power_down_pin),
    .route_valid(route_valid), .tx_enable(tx_enable), .rx_connect(rx_connect),
    .eq_gain(eq_gain), .pll_bw(pll_bw), .recal_pulse(recal_pulse), .clk_link(clk_link),
    .dru_locked(dru_locked), .tx_bits(tx_bits), .preemph_en(preemph_en), .lane_skew(lane_skew));

/* tics_pkg.sv */
// Purpose: shared constants and types for the tmds input channel select block
// Assumes: 8-bit registers on a two-wire serial bus, 7-bit device address
// Notes: offsets are serial bus byte addresses
package tics_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h02;
    localparam logic [7:0] OFS_ACT_CFG = 8'h03;
    localparam logic [7:0] OFS_TX_PREEMPH = 8'h06;
    localparam logic [7:0] OFS_EQ_AB = 8'h07;
    localparam logic [7:0] OFS_EQ_CD = 8'h08;
    localparam logic [7:0] OFS_PLL_BW = 8'h10;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_CHAN_CTRL = 8'h08;
    localparam logic [7:0] RST_ACT_CFG = 8'h00;
    localparam logic [7:0] RST_TX_PREEMPH = 8'h00;
    localparam logic [7:0] RST_EQ = 8'hcc;
    localparam logic [7:0] RST_PLL_BW = 8'h10;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_AUTO = 2;
    localparam int BIT_HWSEL = 3;
    localparam int BIT_PD = 5;
    localparam int BIT_CM_DET = 4;
    localparam int BIT_OFS10 = 5;
    localparam int BIT_OFS20 = 6;
    localparam int BIT_RECAL = 7;
    localparam int PRE_LSB = 4;
    // pll bandwidth codes
    localparam logic [1:0] PLL_BW_4MHZ = 2'h0;
    localparam logic [1:0] PLL_BW_2MHZ = 2'h1;
    localparam logic [1:0] PLL_BW_1MHZ = 2'h2;
    localparam logic [1:0] PLL_BW_500KHZ = 2'h3;
    // channel codes
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACT_WIN_NS = 2560;
    localparam int ACT_WIN_CYC = ACT_WIN_NS / CLK_PERIOD_NS;
    localparam logic [3:0] I2C_BITS = 4'h8;
    localparam logic [7:0] LFSR_SEED = 8'h5a;
    // serial slave states
    typedef enum logic [6:0] {
        TICS_IDLE = 7'h01,
        TICS_ADDR = 7'h02,
        TICS_ACK = 7'h04,
        TICS_WPTR = 7'h08,
        TICS_WDATA = 7'h10,
        TICS_RDATA = 7'h20,
        TICS_RACK = 7'h40
    } tics_i2c_t;
endpackage

/* tics_src_model.sv */
// Purpose: tmds source model driving sliced clock levels
// Assumes: active sources toggle their clock, idle ones hold still
// Notes: slow gives a longer toggle period
`timescale 1ns/1ps
module tics_src_model (
    // control
    input wire logic [3:0] act,
    input wire logic slow,
    // clock levels, bit0 = channel a
    output logic [3:0] lvl
);
    initial lvl = 4'h0;
    always #(slow ? 150 : 17) lvl = lvl ^ act;
endmodule

/* tics_top.sv */
// Purpose: input channel selection, activity detect, settings and lane skew control
// Assumes: tmds clock activity arrives as sliced levels; link clock is the pixel clock
// Notes: registers are reached only through the two-wire serial slave
//
// Behaviour
// RQ1: after reset, selection comes from the auto and channel select pins
// RQ2: auto mode routes highest-priority active input A..D; none active, output inactive
// RQ3: auto mode reports chosen channel in bits 1:0 of channel_and_power_control
// RQ4: board holds auto pin low and drives select pins for manual selection
// RQ5: writing zero to bit 3 of 0x02 gives the multiplexer to software
// RQ6: software auto bit and select bits act like the external pins
// RQ7: select bits read-only in software auto mode, writable in software manual
// RQ8: bit 4 of 0x03 set: clock common mode at 3.3V means inactive
// RQ9: bit 4 of 0x03 clear: toggling clock means active
// RQ10: bits 5 and 6 of 0x03 add 10mV or 20mV clock input offset
// RQ11: registers 0x07 and 0x08 hold a 4-bit equalizer gain per channel
// RQ12: software should program gain 0xa when tuning is impossible
// RQ13: bits 7:4 of 0x06 set transmit pre-emphasis current
// RQ14: pre-emphasis only in the first bit after each output transition
// RQ15: a 2-bit field sets the recovery pll loop bandwidth, 4MHz default
// RQ16: bit 5 of 0x02 or power-down pin turns outputs off, inputs disconnected
// RQ17: serial interface keeps working during power-down
// RQ18: system holds power-down pin low during power-on
// RQ19: software triggers termination recalibration via bit 7 of 0x03 after power-down
// RQ20: three fifo lanes read on one clock, pointers up to 2 bits apart
// RQ21: lane skew re-randomized at each discontinuity, fixed once locked
// RQ22: channel select pins are inputs only
// RQ23: pll bandwidth at 0x10 encodes 4MHz, 2MHz, 1MHz, 500kHz
// RQ24: select code 0..3 maps to channels A..D
`timescale 1ns/1ps
module tics_top #(
    parameter int NCH = 4,
    parameter int NLANE = 3,
    parameter int ACT_WIN = tics_pkg::ACT_WIN_CYC,
    parameter logic [7:0] RST_PRE = tics_pkg::RST_TX_PREEMPH
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // serial control bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [6:0] dev_addr_pins,
    // selection and power pins
    input wire logic auto_select_pin,
    input wire logic [1:0] input_select_pins,
    input wire logic power_down_pin,
    // per-channel clock detectors
    input wire logic [NCH-1:0] chan_clk_level,
    input wire logic [NCH-1:0] chan_cm_high,
    // analog settings
    output logic [1:0] route_sel,
    output logic route_valid,
    output logic tx_enable,
    output logic rx_connect,
    output logic clk_det_by_cm,
    output logic [1:0] clk_offset_sel,
    output logic [4*NCH-1:0] eq_gain,
    output logic [3:0] preemph_code,
    output logic [1:0] pll_bw,
    output logic recal_pulse,
    // link side, pixel clock domain
    input wire logic clk_link,
    input wire logic dru_locked,
    input wire logic [NLANE-1:0] tx_bits,
    output logic [NLANE-1:0] preemph_en,
    output logic [2*NLANE-1:0] lane_skew
);
    import tics_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [1:0] prio_pick(input logic [3:0] act);
        return act[0] ? CH_A : (act[1] ? CH_B : (act[2] ? CH_C : CH_D));
    endfunction

    // two random bits to offset 0..2, 1 most likely
    function automatic logic [1:0] skew_map(input logic [1:0] rnd);
        return (rnd == 2'h3) ? 2'h2 : ((rnd == 2'h0) ? 2'h0 : 2'h1);
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] scl_sync_ff, sda_sync_ff;
    logic scl_d_ff, sda_d_ff;
    logic [6:0] addr_s1_ff, addr_s2_ff;
    logic auto_s1_ff, auto_s2_ff, pd_s1_ff, pd_s2_ff;
    logic [1:0] sel_s1_ff, sel_s2_ff;
    logic [NCH-1:0] ck_s1_ff, ck_s2_ff, ck_d_ff, cm_s1_ff, cm_s2_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            addr_s1_ff <= 7'h00;
            addr_s2_ff <= 7'h00;
            auto_s1_ff <= 1'b0;
            auto_s2_ff <= 1'b0;
            sel_s1_ff <= 2'h0;
            sel_s2_ff <= 2'h0;
            pd_s1_ff <= 1'b0;
            pd_s2_ff <= 1'b0;
            ck_s1_ff <= '0;
            ck_s2_ff <= '0;
            ck_d_ff <= '0;
            cm_s1_ff <= '1;
            cm_s2_ff <= '1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
            addr_s1_ff <= dev_addr_pins;
            addr_s2_ff <= addr_s1_ff;
            auto_s1_ff <= auto_select_pin;
            auto_s2_ff <= auto_s1_ff;
            sel_s1_ff <= input_select_pins; // RQ22
            sel_s2_ff <= sel_s1_ff;
            pd_s1_ff <= power_down_pin;
            pd_s2_ff <= pd_s1_ff;
            ck_s1_ff <= chan_clk_level;
            ck_s2_ff <= ck_s1_ff;
            ck_d_ff <= ck_s2_ff;
            cm_s1_ff <= chan_cm_high;
            cm_s2_ff <= cm_s1_ff;
        end
    end

    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    assign scl_rise = scl_sync_ff[1] & ~scl_d_ff;
    assign scl_fall = ~scl_sync_ff[1] & scl_d_ff;
    assign i2c_start = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
    assign i2c_stop = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] chan_ctrl_ff, act_cfg_ff, pre_ff, eq_ab_ff, eq_cd_ff, pll_ff;
    logic wr_stb_ff;
    logic [7:0] wr_addr_ff, wr_data_ff, rd_data;
    logic [1:0] cur_sel_ff;
    logic recal_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            chan_ctrl_ff <= RST_CHAN_CTRL; // RQ1
            act_cfg_ff <= RST_ACT_CFG;
            pre_ff <= RST_PRE;
            eq_ab_ff <= RST_EQ;
            eq_cd_ff <= RST_EQ;
            pll_ff <= RST_PLL_BW;
            recal_ff <= 1'b0;
        end else begin
            recal_ff <= 1'b0;
            if (wr_stb_ff) begin
                case (wr_addr_ff)
                    OFS_CHAN_CTRL: begin
                        chan_ctrl_ff[7:2] <= wr_data_ff[7:2]; // RQ5 RQ16
                        // select bits read-only in software auto
                        if (!(!wr_data_ff[BIT_HWSEL] && wr_data_ff[BIT_AUTO])) begin
                            chan_ctrl_ff[1:0] <= wr_data_ff[1:0]; // RQ7
                        end
                    end
                    OFS_ACT_CFG: begin
                        act_cfg_ff <= {1'b0, wr_data_ff[6:0]}; // RQ8 RQ9 RQ10
                        recal_ff <= wr_data_ff[BIT_RECAL]; // RQ19
                    end
                    OFS_TX_PREEMPH: pre_ff <= wr_data_ff; // RQ13
                    OFS_EQ_AB: eq_ab_ff <= wr_data_ff; // RQ11
                    OFS_EQ_CD: eq_cd_ff <= wr_data_ff; // RQ11
                    OFS_PLL_BW: pll_ff <= wr_data_ff; // RQ15 RQ23
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // activity detection
    // ************************************************************
    logic [NCH-1:0] ac_seen_ff, ac_act_ff;
    logic [$clog2(ACT_WIN)-1:0] win_cnt_ff;
    logic [NCH-1:0] active;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            win_cnt_ff <= '0;
            ac_seen_ff <= '0;
            ac_act_ff <= '0;
        end else begin
            win_cnt_ff <= win_cnt_ff + 1'b1;
            if (win_cnt_ff == '1) begin
                ac_act_ff <= ac_seen_ff | (ck_s2_ff ^ ck_d_ff); // RQ9
                ac_seen_ff <= '0;
            end else begin
                ac_seen_ff <= ac_seen_ff | (ck_s2_ff ^ ck_d_ff);
            end
        end
    end

    assign active = act_cfg_ff[BIT_CM_DET] ? ~cm_s2_ff : ac_act_ff; // RQ8 RQ9

    // ************************************************************
    // channel selection and power
    // ************************************************************
    logic hw_mode, auto_eff, pd_eff;
    logic [1:0] man_sel;
    logic [3:0] act4;
    logic disc_tgl_ff;

    assign hw_mode = chan_ctrl_ff[BIT_HWSEL];
    assign auto_eff = hw_mode ? auto_s2_ff : chan_ctrl_ff[BIT_AUTO]; // RQ1 RQ6
    assign man_sel = hw_mode ? sel_s2_ff : chan_ctrl_ff[1:0]; // RQ5 RQ6 RQ24
    assign pd_eff = chan_ctrl_ff[BIT_PD] | pd_s2_ff; // RQ16
    assign act4 = 4'(active);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_sel_ff <= CH_A;
            route_valid <= 1'b0;
            tx_enable <= 1'b0;
            rx_connect <= 1'b0;
            disc_tgl_ff <= 1'b0;
        end else begin
            if (auto_eff) begin
                if (act4 != 4'h0) begin
                    cur_sel_ff <= prio_pick(act4); // RQ2 RQ24
                end
                route_valid <= (act4 != 4'h0) & ~pd_eff; // RQ2
            end else begin
                cur_sel_ff <= man_sel;
                route_valid <= ~pd_eff;
            end
            tx_enable <= ~pd_eff; // RQ16
            rx_connect <= ~pd_eff;
            // route or power change is a discontinuity
            if ((route_sel != cur_sel_ff) || (tx_enable == pd_eff)) begin
                disc_tgl_ff <= ~disc_tgl_ff; // RQ21
            end
        end
    end

    // ************************************************************
    // settings outputs
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            route_sel <= CH_A;
            clk_det_by_cm <= 1'b0;
            clk_offset_sel <= 2'h0;
            eq_gain <= '0;
            preemph_code <= 4'h0;
            pll_bw <= PLL_BW_4MHZ;
            recal_pulse <= 1'b0;
        end else begin
            route_sel <= cur_sel_ff; // RQ3
            clk_det_by_cm <= act_cfg_ff[BIT_CM_DET];
            clk_offset_sel <= {act_cfg_ff[BIT_OFS20], act_cfg_ff[BIT_OFS10]}; // RQ10
            eq_gain <= (4*NCH)'({eq_cd_ff, eq_ab_ff}); // RQ11
            preemph_code <= pre_ff[PRE_LSB +: 4]; // RQ13
            pll_bw <= pll_ff[1:0]; // RQ15 RQ23
            recal_pulse <= recal_ff; // RQ19
        end
    end

    // ************************************************************
    // serial slave
    // ************************************************************
    tics_i2c_t st_ff, ack_to_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff, ptr_ff;
    logic rw_ff, nack_ff;

    always_comb begin
        case (ptr_ff)
            OFS_CHAN_CTRL: rd_data = {chan_ctrl_ff[7:2], cur_sel_ff}; // RQ3 RQ7
            OFS_ACT_CFG: rd_data = act_cfg_ff;
            OFS_TX_PREEMPH: rd_data = pre_ff;
            OFS_EQ_AB: rd_data = eq_ab_ff;
            OFS_EQ_CD: rd_data = eq_cd_ff;
            OFS_PLL_BW: rd_data = pll_ff;
            default: rd_data = 8'h00;
        endcase
    end

    // on clk_sys only, so power-down never stops it
    always_ff @(posedge clk_sys or negedge nrst) begin // RQ17
        if (!nrst) begin
            st_ff <= TICS_IDLE;
            ack_to_ff <= TICS_WPTR;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            nack_ff <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr_stb_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_stb_ff <= 1'b0;
            if (i2c_start) begin
                st_ff <= TICS_ADDR;
                bit_cnt_ff <= 4'h0;
                sda_oe <= 1'b0;
            end else if (i2c_stop) begin
                st_ff <= TICS_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_ff)
                    TICS_ADDR, TICS_WPTR, TICS_WDATA: begin
                        if (scl_rise && bit_cnt_ff != I2C_BITS) begin
                            shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == I2C_BITS) begin
                            sda_oe <= 1'b1;
                            st_ff <= TICS_ACK;
                            if (st_ff == TICS_ADDR) begin
                                rw_ff <= shift_ff[0];
                                ack_to_ff <= shift_ff[0] ? TICS_RDATA : TICS_WPTR;
                                if (shift_ff[7:1] != addr_s2_ff) begin
                                    sda_oe <= 1'b0;
                                    st_ff <= TICS_IDLE;
                                end
                            end else if (st_ff == TICS_WPTR) begin
                                ptr_ff <= shift_ff;
                                ack_to_ff <= TICS_WDATA;
                            end else begin
                                wr_stb_ff <= 1'b1;
                                wr_addr_ff <= ptr_ff;
                                wr_data_ff <= shift_ff;
                                ptr_ff <= ptr_ff + 8'h01;
                                ack_to_ff <= TICS_WDATA;
                            end
                        end
                    end
                    TICS_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= 4'h0;
                            if (ack_to_ff == TICS_RDATA) begin
                                shift_ff <= rd_data;
                                sda_oe <= ~rd_data[7];
                                ptr_ff <= ptr_ff + 8'h01;
                                st_ff <= TICS_RDATA;
                            end else begin
                                sda_oe <= 1'b0;
                                st_ff <= ack_to_ff;
                            end
                        end
                    end
                    TICS_RDATA: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            if (bit_cnt_ff == I2C_BITS - 4'h1) begin
                                sda_oe <= 1'b0;
                                st_ff <= TICS_RACK;
                            end else begin
                                sda_oe <= ~shift_ff[6];
                                shift_ff <= {shift_ff[6:0], 1'b0};
                            end
                        end
                    end
                    TICS_RACK: begin
                        if (scl_rise) begin
                            nack_ff <= sda_sync_ff[1];
                        end else if (scl_fall) begin
                            if (nack_ff) begin
                                st_ff <= TICS_IDLE;
                            end else begin
                                shift_ff <= rd_data;
                                sda_oe <= ~rd_data[7];
                                ptr_ff <= ptr_ff + 8'h01;
                                bit_cnt_ff <= 4'h0;
                                st_ff <= TICS_RDATA;
                            end
                        end
                    end
                    default: st_ff <= TICS_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // link domain: pre-emphasis and lane skew
    // ************************************************************
    logic [2:0] disc_sync_ff;
    logic [1:0] pre_on_sync_ff;
    logic [NLANE-1:0] prev_bits_ff;
    logic [7:0] lfsr_ff;
    logic hold_ff;

    always_ff @(posedge clk_link or negedge nrst) begin
        if (!nrst) begin
            disc_sync_ff <= 3'h0;
            pre_on_sync_ff <= 2'h0;
            prev_bits_ff <= '0;
            preemph_en <= '0;
        end else begin
            disc_sync_ff <= {disc_sync_ff[1:0], disc_tgl_ff};
            pre_on_sync_ff <= {pre_on_sync_ff[0], (pre_ff[PRE_LSB +: 4] != 4'h0)};
            prev_bits_ff <= tx_bits;
            // boost the bit after a transition
            preemph_en <= (tx_bits ^ prev_bits_ff) & {NLANE{pre_on_sync_ff[1]}}; // RQ14
        end
    end

    // one read clock for all lanes
    always_ff @(posedge clk_link or negedge nrst) begin // RQ20
        if (!nrst) begin
            lfsr_ff <= LFSR_SEED;
            hold_ff <= 1'b0;
            lane_skew <= '0;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            if (disc_sync_ff[2] != disc_sync_ff[1]) begin
                hold_ff <= 1'b0; // RQ21
            end else if (dru_locked) begin
                hold_ff <= 1'b1; // RQ21
            end
            if (!hold_ff) begin
                for (int i = 0; i < NLANE; i++) begin
                    lane_skew[2*i +: 2] <= skew_map(lfsr_ff[(2*i) % 8 +: 2]); // RQ20
                end
            end
        end
    end
endmodule

/* tics_top_tb_top.sv */
// Purpose: self-checking bench for tics_top
// Assumes: bit-banged serial master, half period 8 clocks
// Notes: activity window shortened to 8 clocks
`timescale 1ns/1ps
module tics_top_tb_top;
    import tics_pkg::*;
    localparam logic [6:0] DEV = 7'h2a; // arbitrary strap
    logic clk_sys = 0, clk_link = 0, nrst = 0, scl = 1, sdm = 1, auto_p = 0, pd_p = 0;
    logic slow = 0, lock = 0, sda_out, sda_oe, route_valid, tx_enable, rx_connect, det, rcl;
    logic [1:0] sel_p = 0, route_sel, ofs_sel, pll_bw;
    logic [3:0] act = 0, cmh = 0, lvl, pre;
    logic [2:0] txb = 0;
    logic [15:0] eq_gain;
    logic [8:0] q;
    logic [7:0] ofs [3] = '{OFS_TX_PREEMPH, OFS_EQ_AB, OFS_EQ_CD};
    logic [7:0] val [3] = '{8'hf0, 8'haa, 8'h3c};
    int n_mismatch = 0, compares = 0, n_rcl = 0;
    wire sda = sdm & ~sda_oe;
    always #20 clk_sys = ~clk_sys;
    always @(negedge clk_sys) n_rcl += rcl;
    initial #1.7 forever #3 clk_link = ~clk_link;
    always @(negedge clk_link) txb <= nrst ? txb + 3'h3 : 3'h0;
    tics_src_model src (.act(act), .slow(slow), .lvl(lvl));
    tics_top #(.ACT_WIN(8)) uut (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr_pins(DEV), .auto_select_pin(auto_p),
        .input_select_pins(sel_p), .power_down_pin(pd_p), .chan_clk_level(lvl),
        .chan_cm_high(cmh), .route_sel(route_sel), .route_valid(route_valid),
        .tx_enable(tx_enable), .rx_connect(rx_connect), .clk_det_by_cm(det),
        .clk_offset_sel(ofs_sel), .eq_gain(eq_gain), .preemph_code(pre), .pll_bw(pll_bw),
        .recal_pulse(rcl), .clk_link(clk_link), .dru_locked(lock), .tx_bits(txb),
        .preemph_en(), .lane_skew());
    task test_done;
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task pins(input logic c, input logic d);
        scl = c;
        sdm = d;
        repeat (8) @(negedge clk_sys);
    endtask
    task xb(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            pins(0, d[i]);
            pins(1, d[i]);
            q[i] = sda;
        end
        pins(0, d[0]);
    endtask
    task start(input logic r);
        pins(0, 1);
        pins(1, 1);
        pins(1, 0);
        xb({DEV, r, 1'b1});
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        start(0);
        xb({a, 1'b1});
        xb({v, 1'b1});
        chk("ack", 0, q[0]);
        pins(0, 0);
        pins(1, 0);
        pins(1, 1);
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        start(0);
        xb({a, 1'b1});
        start(1);
        xb(9'h1ff);
        chk("reg", e, q[8:1]);
        pins(0, 0);
        pins(1, 0);
        pins(1, 1);
    endtask
    task ws(input logic [1:0] e, input logic v);
        int i;
        for (i = 0; i < 300 && !(route_sel === e && route_valid === v); i++) @(negedge clk_sys);
        chk("route", {v, e}, {route_valid, route_sel});
        if (i == 300) test_done;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        nrst = 1;
        rc(OFS_CHAN_CTRL, RST_CHAN_CTRL);
        rc(8'h05, 8'h00);
        chk("eq", 16'hcccc, eq_gain);
        for (int c = 0; c < 4; c++) begin
            sel_p = c[1:0];
            ws(c[1:0], 1);
        end
        auto_p = 1;
        for (int c = 0; c < 4; c++) begin
            act = 4'hf << c;
            ws(c[1:0], 1);
            rc(OFS_CHAN_CTRL, {6'h02, c[1:0]});
        end
        act = 4'h0;
        ws(3, 0);
        slow = 1;
        act = 4'h2;
        ws(1, 1);
        cmh = 4'h3;
        wr(OFS_ACT_CFG, 8'h70);
        chk("det", 3'h7, {det, ofs_sel});
        ws(2, 1);
        cmh = 4'hf;
        ws(2, 0);
        wr(OFS_ACT_CFG, 8'h80);
        rc(OFS_ACT_CFG, 8'h00);
        chk("recal", 1, n_rcl);
        act = 4'h1;
        wr(OFS_CHAN_CTRL, 8'h01);
        ws(1, 1);
        act = 4'h8;
        wr(OFS_CHAN_CTRL, 8'h06);
        ws(3, 1);
        rc(OFS_CHAN_CTRL, 8'h07);
        wr(OFS_CHAN_CTRL, 8'h25);
        ws(3, 0);
        chk("pwr", 0, {tx_enable, rx_connect});
        rc(OFS_CHAN_CTRL, 8'h27);
        wr(OFS_CHAN_CTRL, 8'h06);
        ws(3, 1);
        pd_p = 1;
        rc(OFS_CHAN_CTRL, 8'h07);
        chk("pwr", 0, {tx_enable, rx_connect, route_valid});
        pd_p = 0;
        for (int k = 0; k < 3; k++) begin
            wr(ofs[k], val[k]);
            rc(ofs[k], val[k]);
        end
        chk("set", {16'h3caa, 4'hf}, {eq_gain, pre});
        lock = 1;
        for (int b = 0; b < 4; b++) begin
            wr(OFS_PLL_BW, {6'h04, b[1:0]});
            chk("pll", b[1:0], pll_bw);
        end
        test_done;
    end
endmodule
